/* File: hw/eeprom_link_pkg.sv */
// Shared constants for both ends of the two-wire serial EEPROM link.
// Assumes both ends run from a 25 MHz core clock.
`default_nettype none
package eeprom_link_pkg;
    // Core clock
    localparam int CLK_PERIOD_NS = 40;
    // Line filter: pulses up to this width are dropped
    localparam int SPIKE_FILTER_WIDTH_NS = 50;
    localparam int SPIKE_FILTER_CYC = (SPIKE_FILTER_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FILT_CNT_W = 2;
    // Data hold after a falling clock edge
    localparam int TX_HOLD_NS = 300;
    localparam int TX_HOLD_CYC = (TX_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_CNT_W = 4;
    // Self-timed write cycle, longest allowed
    localparam int WRITE_CYCLE_MS = 5;
    localparam int WRITE_CYCLE_CYC = WRITE_CYCLE_MS * 1000000 / CLK_PERIOD_NS;
    localparam int WC_CNT_W = 20;
    // Master clock shaping, least times
    localparam int SCL_LOW_NS = 1300;
    localparam int SCL_HIGH_NS = 600;
    localparam int BUS_FREE_NS = 1300;
    localparam int SCL_LOW_CYC = (SCL_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SCL_HIGH_CYC = (SCL_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BUS_FREE_CYC = (BUS_FREE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TMR_W = 6;
    // Array and byte framing
    localparam int ADDR_W = 12;
    localparam int PAGE_SIZE = 32;
    localparam int PAGE_W = 5;
    localparam int BIT_CNT_W = 4;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic [3:0] ACK_DONE = 4'h9;
    // Reset values of synchronisers: lines idle high, straps low
    localparam logic [5:0] SYNC_RESET = 6'h03;
    // Master register map
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_ACK_BIT = 2;
    localparam int CMD_DATA_LSB = 8;
    localparam int STS_BUSY_BIT = 0;
    localparam int STS_NACK_BIT = 1;
    localparam int STS_DATA_LSB = 8;
    typedef enum logic [1:0] {OP_START, OP_STOP, OP_WRITE, OP_READ} op_type;
endpackage : eeprom_link_pkg
`default_nettype wire

/* File: hw/eeprom_link_if.sv */
// Two-wire link between bus master and EEPROM slave.
// Resolves the open-drain lines with an implied pull-up.
`timescale 1ns/1ps
`default_nettype none
interface eeprom_link_if;
    logic scl_o;
    logic scl_oe;
    logic sda_m_o;
    logic sda_m_oe;
    logic sda_s_o;
    logic sda_s_oe;
    logic scl;
    logic sda;
    // Wired-AND of every driver
    assign scl = !(scl_oe && !scl_o);
    assign sda = !(sda_m_oe && !sda_m_o) && !(sda_s_oe && !sda_s_o);
    modport master (output scl_o, output scl_oe, output sda_m_o, output sda_m_oe,
                    input scl, input sda);
    modport device (output sda_s_o, output sda_s_oe, input scl, input sda);
endinterface : eeprom_link_if
`default_nettype wire

/* File: hw/serial_eeprom_bus_slave.sv */
// Serial slave front end of a 4K x 8 EEPROM with a 32-byte page buffer.
// Assumes the array reads mem_rd_data from mem_addr within one cycle.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Write cycle ends within 5 ms
// - Drop line pulses of 50 ns or less
// - Hold data 300 ns after clock falls
// - Master alone clocks and frames the bus
// - Master starts only on an idle bus
// - Data change at clock high means framing
// - Data falling at clock high is Start
// - Data rising at clock high is Stop
// - One clock per bit, change when low
// - Page buffer keeps last thirty-two bytes
// - Every received byte acknowledged on ninth clock
// - No acknowledge while programming
// - Acknowledge held low through clock high
// - Master NACK ends read, line released
// - Control byte: type, selects, direction
// - Respond only when selects match pins
// - Direction bit one reads, zero writes
// - Two address bytes, high first, twelve bits
// - Matching control byte acknowledged, then dispatch
// - Stop starts write unless protect high
// - Page pointer low five bits wrap
// - Read pointer increments, wraps at top
module serial_eeprom_bus_slave #(
    parameter int WRITE_CYCLE_CYC = eeprom_link_pkg::WRITE_CYCLE_CYC,
    parameter logic [3:0] DEVICE_TYPE_CODE = 4'h5 // Arbitrary value
) (
    input wire logic core_clk,
    input wire logic rst,
    eeprom_link_if.device link,
    input wire logic chip_select_pin_hi,
    input wire logic chip_select_pin_mid,
    input wire logic chip_select_pin_lo,
    input wire logic write_protect,
    output logic [eeprom_link_pkg::ADDR_W-1:0] mem_addr,
    input wire logic [7:0] mem_rd_data,
    output logic commit_start,
    output logic [eeprom_link_pkg::ADDR_W-1:0] commit_addr,
    output logic [eeprom_link_pkg::PAGE_SIZE-1:0] commit_mask,
    input wire logic [eeprom_link_pkg::PAGE_W-1:0] buf_index,
    output logic [7:0] buf_data,
    output logic write_busy
);
    import eeprom_link_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE, ST_CTRL, ST_ADDR_HI, ST_ADDR_LO, ST_WRITE, ST_READ, ST_IGNORE
    } state_type;

    logic [5:0] pins_s1_q;
    logic [5:0] pins_s2_q;
    logic [1:0] line_f;
    logic [1:0] line_p_q;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    logic active;
    logic [2:0] cs_pins;
    state_type state_q, state_d;
    logic [BIT_CNT_W-1:0] bit_q, bit_d;
    logic [7:0] rx_q, rx_d;
    logic [7:0] tx_q, tx_d;
    logic [ADDR_W-1:0] ptr_q, ptr_d;
    logic mack_q, mack_d;
    logic txing_q, txing_d;
    logic want_low_q, want_low_d;
    logic [7:0] page_q [PAGE_SIZE];
    logic [7:0] page_d [PAGE_SIZE];
    logic [PAGE_SIZE-1:0] mask_q, mask_d;
    logic commit_q, commit_d;
    logic [ADDR_W-1:0] caddr_q, caddr_d;
    logic [PAGE_SIZE-1:0] cmask_q, cmask_d;
    logic [7:0] buf_data_q;
    logic [HOLD_CNT_W-1:0] hold_q, hold_d;
    logic sda_low_q, sda_low_d;
    logic busy_q, busy_d;
    logic [WC_CNT_W-1:0] wc_q, wc_d;

    // Two-flop synchronisers: {protect, selects, data, clock}
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pins_s1_q <= SYNC_RESET;
            pins_s2_q <= SYNC_RESET;
        end else begin
            pins_s1_q <= {write_protect, chip_select_pin_hi, chip_select_pin_mid,
                          chip_select_pin_lo, link.sda, link.scl};
            pins_s2_q <= pins_s1_q;
        end
    end

    // Spike filter per line: level moves only after a steady run
    for (genvar i = 0; i < 2; i++) begin : g_filter
        logic [FILT_CNT_W-1:0] cnt_q, cnt_d;
        logic lvl_q, lvl_d;
        always_comb begin
            lvl_d = lvl_q;
            cnt_d = '0;
            if (pins_s2_q[i] != lvl_q) begin
                cnt_d = cnt_q + 1'b1;
                if (cnt_q == FILT_CNT_W'(SPIKE_FILTER_CYC)) begin
                    lvl_d = pins_s2_q[i];
                    cnt_d = '0;
                end
            end
        end
        always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
                cnt_q <= '0;
                lvl_q <= 1'b1;
            end else begin
                cnt_q <= cnt_d;
                lvl_q <= lvl_d;
            end
        end
        assign line_f[i] = lvl_q;
    end

    // Previous filtered levels for edge detection
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            line_p_q <= 2'h3;
        end else begin
            line_p_q <= line_f;
        end
    end

    // Bus events; any data edge at clock high frames the bus
    assign scl_rise = line_f[0] && !line_p_q[0];
    assign scl_fall = !line_f[0] && line_p_q[0];
    assign start_ev = line_f[0] && line_p_q[0] && line_p_q[1] && !line_f[1];
    assign stop_ev = line_f[0] && line_p_q[0] && !line_p_q[1] && line_f[1];
    assign active = (state_q != ST_IDLE) && (state_q != ST_IGNORE);
    assign cs_pins = pins_s2_q[4:2];

    // Protocol engine: framing, byte decode, pointer and page buffer
    always_comb begin
        state_d = state_q;
        bit_d = bit_q;
        rx_d = rx_q;
        tx_d = tx_q;
        ptr_d = ptr_q;
        mack_d = mack_q;
        txing_d = txing_q;
        want_low_d = want_low_q;
        page_d = page_q;
        mask_d = mask_q;
        commit_d = 1'b0;
        caddr_d = caddr_q;
        cmask_d = cmask_q;
        if (start_ev) begin
            state_d = ST_CTRL;
            bit_d = '0;
            want_low_d = 1'b0;
            txing_d = 1'b0;
        end else if (stop_ev) begin
            state_d = ST_IDLE;
            want_low_d = 1'b0;
            txing_d = 1'b0;
            if (state_q == ST_WRITE && mask_q != '0 && !busy_q && !pins_s2_q[5]) begin
                commit_d = 1'b1;
                caddr_d = {ptr_q[ADDR_W-1:PAGE_W], PAGE_W'(0)};
                cmask_d = mask_q;
            end
        end else if (active && scl_rise) begin
            bit_d = bit_q + 1'b1;
            if (bit_q == ACK_SLOT) begin
                mack_d = !line_f[1];
                if (state_q == ST_READ && txing_q) begin
                    ptr_d = ptr_q + 1'b1;
                end
            end else begin
                rx_d = {rx_q[6:0], line_f[1]};
            end
        end else if (active && scl_fall) begin
            if (bit_q == ACK_SLOT) begin
                want_low_d = 1'b1;
                unique case (state_q)
                    ST_CTRL: begin
                        if (rx_q[7:4] == DEVICE_TYPE_CODE && rx_q[3:1] == cs_pins
                            && !busy_q) begin
                            state_d = rx_q[0] ? ST_READ : ST_ADDR_HI;
                            mask_d = rx_q[0] ? mask_q : '0;
                        end else begin
                            state_d = ST_IGNORE;
                            want_low_d = 1'b0;
                        end
                    end
                    ST_ADDR_HI: begin
                        ptr_d[ADDR_W-1:8] = rx_q[3:0];
                        state_d = ST_ADDR_LO;
                    end
                    ST_ADDR_LO: begin
                        ptr_d[7:0] = rx_q;
                        state_d = ST_WRITE;
                    end
                    ST_WRITE: begin
                        page_d[ptr_q[PAGE_W-1:0]] = rx_q;
                        mask_d[ptr_q[PAGE_W-1:0]] = 1'b1;
                        ptr_d[PAGE_W-1:0] = ptr_q[PAGE_W-1:0] + 1'b1;
                    end
                    ST_READ: begin
                        want_low_d = 1'b0;
                    end
                    default: begin
                        want_low_d = 1'b0;
                    end
                endcase
            end else if (bit_q == ACK_DONE) begin
                bit_d = '0;
                want_low_d = 1'b0;
                if (state_q == ST_READ) begin
                    if (mack_q) begin
                        tx_d = mem_rd_data;
                        txing_d = 1'b1;
                        want_low_d = !mem_rd_data[7];
                    end else begin
                        state_d = ST_IGNORE;
                        txing_d = 1'b0;
                    end
                end
            end else if (state_q == ST_READ && txing_q) begin
                want_low_d = !tx_q[3'(4'd7 - bit_q)];
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            bit_q <= '0;
            rx_q <= '0;
            tx_q <= '0;
            ptr_q <= '0;
            mack_q <= 1'b0;
            txing_q <= 1'b0;
            want_low_q <= 1'b0;
            page_q <= '{default: '0};
            mask_q <= '0;
            commit_q <= 1'b0;
            caddr_q <= '0;
            cmask_q <= '0;
        end else begin
            state_q <= state_d;
            bit_q <= bit_d;
            rx_q <= rx_d;
            tx_q <= tx_d;
            ptr_q <= ptr_d;
            mack_q <= mack_d;
            txing_q <= txing_d;
            want_low_q <= want_low_d;
            page_q <= page_d;
            mask_q <= mask_d;
            commit_q <= commit_d;
            caddr_q <= caddr_d;
            cmask_q <= cmask_d;
        end
    end

    // Output stage: new level after the hold delay from clock fall; Start and Stop release at once
    always_comb begin
        hold_d = hold_q;
        sda_low_d = sda_low_q;
        if (start_ev || stop_ev) begin
            hold_d = '0;
            sda_low_d = 1'b0;
        end else if (scl_fall) begin
            hold_d = HOLD_CNT_W'(TX_HOLD_CYC);
        end else if (hold_q != '0) begin
            hold_d = hold_q - 1'b1;
            if (hold_q == HOLD_CNT_W'(1)) begin
                sda_low_d = want_low_q;
            end
        end
    end

    // Write-cycle timer; busy blocks acknowledges
    always_comb begin
        busy_d = busy_q;
        wc_d = wc_q;
        if (commit_q) begin
            busy_d = 1'b1;
            wc_d = '0;
        end else if (busy_q) begin
            wc_d = wc_q + 1'b1;
            if (wc_q == WC_CNT_W'(WRITE_CYCLE_CYC - 1)) begin
                busy_d = 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            hold_q <= '0;
            sda_low_q <= 1'b0;
            busy_q <= 1'b0;
            wc_q <= '0;
            buf_data_q <= '0;
        end else begin
            hold_q <= hold_d;
            sda_low_q <= sda_low_d;
            busy_q <= busy_d;
            wc_q <= wc_d;
            buf_data_q <= page_q[buf_index];
        end
    end

    // Open-drain data pin; clock is input only
    assign link.sda_s_o = 1'b0;
    assign link.sda_s_oe = sda_low_q;
    assign mem_addr = ptr_q;
    assign commit_start = commit_q;
    assign commit_addr = caddr_q;
    assign commit_mask = cmask_q;
    assign buf_data = buf_data_q;
    assign write_busy = busy_q;
endmodule : serial_eeprom_bus_slave
`default_nettype wire

/* File: hw/serial_eeprom_bus_master.sv */
// Two-wire bus master: runs Start, Stop, byte write and byte read commands.
// Assumes software issues one command at a time and polls the busy bit.
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_bus_master (
    input wire logic core_clk,
    input wire logic rst,
    eeprom_link_if.master link,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata
);
    import eeprom_link_pkg::*;

    typedef enum logic [3:0] {
        M_IDLE, M_ST_REL, M_ST_HIGH, M_ST_HOLD, M_LOW_HOLD, M_LOW_SETUP, M_HIGH,
        M_SP_LOW, M_SP_HIGH, M_SP_FREE
    } mstate_type;

    mstate_type st_q, st_d;
    logic [TMR_W-1:0] tmr_q, tmr_d;
    logic [BIT_CNT_W-1:0] cnt_q, cnt_d;
    logic [8:0] sh_q, sh_d;
    logic scl_low_q, scl_low_d;
    logic sda_low_q, sda_low_d;
    logic [31:0] rdata_q, rdata_d;
    logic sda_s1_q;
    logic sda_s2_q;
    logic cmd_go;
    op_type op;

    assign cmd_go = reg_wr && reg_addr == REG_CMD && st_q == M_IDLE;
    assign op = op_type'(reg_wdata[CMD_OP_LSB +: 2]);

    // Data line synchroniser
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
        end else begin
            sda_s1_q <= link.sda;
            sda_s2_q <= sda_s1_q;
        end
    end

    // Sequencer: one timed phase per state
    always_comb begin
        st_d = st_q;
        tmr_d = tmr_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        scl_low_d = scl_low_q;
        sda_low_d = sda_low_q;
        if (st_q == M_IDLE) begin
            if (cmd_go) begin
                unique case (op)
                    OP_START: begin
                        st_d = M_ST_REL;
                        tmr_d = TMR_W'(SCL_LOW_CYC);
                        sda_low_d = 1'b0;
                    end
                    OP_STOP: begin
                        st_d = M_SP_LOW;
                        tmr_d = TMR_W'(SCL_LOW_CYC);
                        scl_low_d = 1'b1;
                    end
                    OP_WRITE: begin
                        st_d = M_LOW_HOLD;
                        tmr_d = TMR_W'(TX_HOLD_CYC);
                        scl_low_d = 1'b1;
                        cnt_d = '0;
                        sh_d = {reg_wdata[CMD_DATA_LSB +: 8], 1'b1};
                    end
                    OP_READ: begin
                        st_d = M_LOW_HOLD;
                        tmr_d = TMR_W'(TX_HOLD_CYC);
                        scl_low_d = 1'b1;
                        cnt_d = '0;
                        sh_d = {8'hff, !reg_wdata[CMD_ACK_BIT]};
                    end
                endcase
            end
        end else if (tmr_q != '0) begin
            tmr_d = tmr_q - 1'b1;
        end else begin
            unique case (st_q)
                M_ST_REL: begin
                    st_d = M_ST_HIGH;
                    tmr_d = TMR_W'(SCL_HIGH_CYC);
                    scl_low_d = 1'b0;
                end
                M_ST_HIGH: begin
                    st_d = M_ST_HOLD;
                    tmr_d = TMR_W'(SCL_HIGH_CYC);
                    sda_low_d = 1'b1;
                end
                M_ST_HOLD: begin
                    st_d = M_IDLE;
                    scl_low_d = 1'b1;
                end
                M_LOW_HOLD: begin
                    st_d = M_LOW_SETUP;
                    tmr_d = TMR_W'(SCL_LOW_CYC - TX_HOLD_CYC);
                    sda_low_d = !sh_q[8];
                end
                M_LOW_SETUP: begin
                    st_d = M_HIGH;
                    tmr_d = TMR_W'(SCL_HIGH_CYC);
                    scl_low_d = 1'b0;
                end
                M_HIGH: begin
                    scl_low_d = 1'b1;
                    sh_d = {sh_q[7:0], sda_s2_q};
                    cnt_d = cnt_q + 1'b1;
                    st_d = (cnt_q == ACK_SLOT) ? M_IDLE : M_LOW_HOLD;
                    tmr_d = TMR_W'(TX_HOLD_CYC);
                end
                M_SP_LOW: begin
                    st_d = M_SP_HIGH;
                    tmr_d = TMR_W'(SCL_HIGH_CYC);
                    scl_low_d = 1'b0;
                end
                M_SP_HIGH: begin
                    st_d = M_SP_FREE;
                    tmr_d = TMR_W'(BUS_FREE_CYC);
                    sda_low_d = 1'b0;
                end
                M_SP_FREE: begin
                    st_d = M_IDLE;
                end
                default: begin
                    st_d = M_IDLE;
                end
            endcase
        end
        if (st_q == M_SP_LOW && tmr_q == TMR_W'(SCL_LOW_CYC - TX_HOLD_CYC)) begin
            sda_low_d = 1'b1;
        end
    end

    // Register read path, data one cycle after the strobe
    always_comb begin
        rdata_d = '0;
        if (reg_rd && reg_addr == REG_STATUS) begin
            rdata_d[STS_BUSY_BIT] = st_q != M_IDLE;
            rdata_d[STS_NACK_BIT] = sh_q[0];
            rdata_d[STS_DATA_LSB +: 8] = sh_q[8:1];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_q <= M_IDLE;
            tmr_q <= '0;
            cnt_q <= '0;
            sh_q <= '0;
            scl_low_q <= 1'b0;
            sda_low_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            st_q <= st_d;
            tmr_q <= tmr_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            scl_low_q <= scl_low_d;
            sda_low_q <= sda_low_d;
            rdata_q <= rdata_d;
        end
    end

    // Open-drain drivers for both lines
    assign link.scl_o = 1'b0;
    assign link.scl_oe = scl_low_q;
    assign link.sda_m_o = 1'b0;
    assign link.sda_m_oe = sda_low_q;
    assign reg_rdata = rdata_q;
endmodule : serial_eeprom_bus_master
`default_nettype wire

/* File: testbench/eeprom_link_chk.sv */
// Checker on the two-wire link between the bus master and the EEPROM slave.
// Sees only the resolved lines and the slave's data drive.
`timescale 1ns/1ps
`default_nettype none
module eeprom_link_chk (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_s_o,
    input wire logic sda_s_oe
);
    logic scl_q, sda_q, ctl_q, rd_q;
    logic [3:0] cnt_q;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // Bit count since Start, control byte flag, direction bit
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            ctl_q <= 1'b0;
            rd_q <= 1'b0;
            cnt_q <= 4'h0;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            if (scl && scl_q && sda_q && !sda) begin
                cnt_q <= 4'h0;
                ctl_q <= 1'b1;
                rd_q <= 1'b0;
            end else if (scl && !scl_q) begin
                cnt_q <= (cnt_q == 4'h8) ? 4'h0 : cnt_q + 4'h1;
                if (cnt_q == 4'h8) ctl_q <= 1'b0;
                if (ctl_q && cnt_q == 4'h7) rd_q <= sda;
            end
        end
    end
    property p_od; sda_s_oe |-> !sda_s_o; endproperty
    property p_hold; $fell(scl) |=> $stable(sda_s_oe) [*7]; endproperty
    property p_edge; $rose(sda_s_oe) |-> !scl; endproperty
    property p_ack; $rose(scl) && sda_s_oe |=> sda_s_oe [*8]; endproperty
    property p_ctl; ctl_q && cnt_q != 4'h0 && cnt_q != 4'h8 |-> !sda_s_oe; endproperty
    property p_slot; ctl_q && $rose(sda_s_oe) |-> cnt_q == 4'h8; endproperty
    property p_nack; rd_q && !ctl_q && $rose(scl) && cnt_q == 4'h8 |-> !sda_s_oe; endproperty
    property p_rel;
        !rd_q && !ctl_q && $fell(scl) && cnt_q == 4'h0 && sda_s_oe |-> ##[6:16] !sda_s_oe;
    endproperty
    a_od: assert property (p_od) else $error("slave drives data high");
    a_hold: assert property (p_hold) else $error("data drive moved too soon");
    a_edge: assert property (p_edge) else $error("data pulled with clock high");
    a_ack: assert property (p_ack) else $error("acknowledge not held");
    a_ctl: assert property (p_ctl) else $error("drive during control byte");
    a_slot: assert property (p_slot) else $error("acknowledge off its slot");
    a_nack: assert property (p_nack) else $error("line held in master slot");
    a_rel: assert property (p_rel) else $error("acknowledge not released");
    c_ack: cover property ($rose(scl) && sda_s_oe);
    c_ctl: cover property (ctl_q && cnt_q == 4'h8 && sda_s_oe);
    c_rd: cover property (rd_q && !ctl_q && $rose(scl) && cnt_q == 4'h8);
endmodule : eeprom_link_chk
`default_nettype wire

/* File: testbench/tb.sv */
// Self-checking bench: master and EEPROM slave joined over the link.
// Drives the master's register port; the array returns a fixed pattern.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin n_mismatch++; \
    $display("unexpected %s expected %h seen %h", nm, e, s); end end
module tb;
    import eeprom_link_pkg::*;
    localparam int WC = 1000;
    localparam logic [3:0] TYPE_CODE = 4'h9; // Arbitrary value
    localparam logic [7:0] CTL_W = {TYPE_CODE, 3'b101, 1'b0};
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0, reg_rd = 1'b0, wp = 1'b0;
    logic [2:0] cs = 3'h5;
    logic [31:0] reg_rdata, st;
    logic [ADDR_W-1:0] mem_addr, commit_addr, c_addr;
    logic [7:0] mem_rd_data, buf_data;
    logic commit_start, write_busy;
    logic [PAGE_SIZE-1:0] commit_mask, c_mask;
    logic [PAGE_W-1:0] buf_index = 5'h00;
    int n_mismatch = 0, compares = 0, n_commit = 0, busy_cyc = 0, cyc = 0;
    eeprom_link_if link ();
    serial_eeprom_bus_master serial_eeprom_bus_master_inst (.core_clk(core_clk), .rst(rst),
        .link(link.master), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    serial_eeprom_bus_slave #(.WRITE_CYCLE_CYC(WC), .DEVICE_TYPE_CODE(TYPE_CODE))
        serial_eeprom_bus_slave_inst (.core_clk(core_clk), .rst(rst), .link(link.device),
        .chip_select_pin_hi(cs[2]), .chip_select_pin_mid(cs[1]), .chip_select_pin_lo(cs[0]),
        .write_protect(wp), .mem_addr(mem_addr), .mem_rd_data(mem_rd_data),
        .commit_start(commit_start), .commit_addr(commit_addr), .commit_mask(commit_mask),
        .buf_index(buf_index), .buf_data(buf_data), .write_busy(write_busy));
    eeprom_link_chk eeprom_link_chk_inst (.core_clk(core_clk), .rst(rst), .scl(link.scl),
        .sda(link.sda), .sda_s_o(link.sda_s_o), .sda_s_oe(link.sda_s_oe));
    // Array pattern
    assign mem_rd_data = mem_addr[7:0] ^ 8'h5a;
    always #20 core_clk = ~core_clk;
    // Array side monitor and cycle ceiling
    always @(posedge core_clk) begin
        cyc++;
        if (write_busy === 1'b1) busy_cyc++;
        if (commit_start === 1'b1) begin
            n_commit++;
            c_addr = commit_addr;
            c_mask = commit_mask;
        end
        if (cyc == 60000) begin
            n_mismatch++;
            results();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        st = reg_rdata;
    endtask : rd
    // One master command, then poll until idle
    task automatic cmd(input op_type op, input logic [7:0] b, input logic ack);
        wr(REG_CMD, {16'h0, b, 5'h0, ack, op});
        do rd(REG_STATUS); while (st[STS_BUSY_BIT] !== 1'b0);
    endtask : cmd
    task automatic tx(input logic [7:0] b, input logic nack);
        cmd(OP_WRITE, b, 1'b0);
        `CHK("ack", nack, st[STS_NACK_BIT])
    endtask : tx
    task automatic rx(input logic ack, input logic [7:0] e);
        cmd(OP_READ, 8'h00, ack);
        `CHK("rdata", e, st[15:8])
    endtask : rx
    task automatic results();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : results
    initial begin
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        repeat (10) @(posedge core_clk);
        rd(8'h08);
        `CHK("unmapped", 32'h0, st)
        // Page write wrapping inside its page, upper address bits ignored
        cmd(OP_START, 8'h00, 1'b0);
        tx(CTL_W, 1'b0);
        tx(8'hf1, 1'b0);
        tx(8'h3e, 1'b0);
        tx(8'h11, 1'b0);
        tx(8'h22, 1'b0);
        tx(8'h33, 1'b0);
        cmd(OP_STOP, 8'h00, 1'b0);
        `CHK("commits", 1, n_commit)
        `CHK("page", 12'h120, c_addr)
        `CHK("mask", 32'hc0000001, c_mask)
        `CHK("busy", 1'b1, write_busy)
        @(posedge core_clk);
        buf_index <= 5'h1e;
        repeat (2) @(negedge core_clk);
        `CHK("buf", 8'h11, buf_data)
        // Control byte while programming goes unanswered
        cmd(OP_START, 8'h00, 1'b0);
        tx(CTL_W, 1'b1);
        cmd(OP_STOP, 8'h00, 1'b0);
        while (write_busy !== 1'b0) @(negedge core_clk);
        `CHK("busy time", WC, busy_cyc)
        // Select pins off the control byte, then wrong type code: ignored to next Start
        for (int k = 0; k < 2; k++) begin
            @(posedge core_clk);
            cs <= k ? 3'h5 : 3'h1;
            cmd(OP_START, 8'h00, 1'b0);
            tx(k ? {~TYPE_CODE, 3'b101, 1'b0} : CTL_W, 1'b1);
            tx(8'h00, 1'b1);
            cmd(OP_STOP, 8'h00, 1'b0);
        end
        // Protected write: bytes answered, nothing programmed
        @(posedge core_clk);
        wp <= 1'b1;
        cmd(OP_START, 8'h00, 1'b0);
        tx(CTL_W, 1'b0);
        tx(8'h00, 1'b0);
        tx(8'h40, 1'b0);
        tx(8'h77, 1'b0);
        cmd(OP_STOP, 8'h00, 1'b0);
        `CHK("commits", 1, n_commit)
        `CHK("busy", 1'b0, write_busy)
        @(posedge core_clk);
        wp <= 1'b0;
        // Random read at the top address, then wrap to zero
        cmd(OP_START, 8'h00, 1'b0);
        tx(CTL_W, 1'b0);
        tx(8'h0f, 1'b0);
        tx(8'hff, 1'b0);
        cmd(OP_START, 8'h00, 1'b0);
        tx(CTL_W | 8'h01, 1'b0);
        rx(1'b1, 8'ha5);
        rx(1'b0, 8'h5a);
        cmd(OP_STOP, 8'h00, 1'b0);
        // Current address read goes on after the last byte
        cmd(OP_START, 8'h00, 1'b0);
        tx(CTL_W | 8'h01, 1'b0);
        rx(1'b0, 8'h5b);
        cmd(OP_STOP, 8'h00, 1'b0);
        results();
    end
endmodule : tb
`default_nettype wire
